/* File: hw/spi_status_pkg.sv */
// Shared constants and carriers for the serial status and flag block
package spi_status_pkg;

  // ==========================================================
  // Register addresses on the special-function-register bus
  localparam logic [7:0] ADDR_CONTROL = 8'hF8;
  localparam logic [7:0] ADDR_CONFIG  = 8'hA1;
  localparam logic [7:0] ADDR_DATA    = 8'hA3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h06;
  localparam logic [7:0] CONFIG_RESET  = 8'h07;
  localparam logic [7:0] BYTE_RESET    = 8'h00;

  // ==========================================================
  // Field positions, control register
  localparam int CTL_DONE_BIT    = 7;
  localparam int CTL_TXEMPTY_BIT = 1;
  localparam int CTL_ENABLE_BIT  = 0;

  // ==========================================================
  // Field positions, config register
  localparam int CFG_BUSY_BIT     = 7;
  localparam int CFG_SELECTED_BIT = 3;
  localparam int CFG_LEVEL_BIT    = 2;
  localparam int CFG_SHEMPTY_BIT  = 1;
  localparam int CFG_RXEMPTY_BIT  = 0;

  // ==========================================================
  // Link framing
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] BIT_ZERO = 3'h0;

  // Byte write, bit write or read from the processor
  typedef struct packed {
    logic       wr;
    logic       bit_wr;
    logic       rd;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } sfr_req_t;

endpackage : spi_status_pkg

/* File: hw/spi_status_flags.sv */
// Status, completion flag and slave shifting of a byte serial interface
// Function
// R01: Slave mode sets shifter-empty when all bits moved and nothing to load
// R02: Moving a byte from transmit buffer to shifter clears shifter-empty
// R03: A serial clock transition also clears shifter-empty
// R04: Hardware sets transfer-done flag at the end of every transfer
// R05: Transfer-done flag with interrupts enabled raises the interrupt request
// R06: Transfer-done flag clears only by software write, never by hardware
// R07: Control register at address F8, bit writable, done flag in bit 7
// R08: Slave-selected flag reads 1 while the select pin is low
// R09: Transmit write clears tx-empty; move into shifter sets it again
// R10: Select level bit reads the pin level, without latching
`timescale 1ns/1ps
`default_nettype none

module spi_status_flags (
  // System clock and reset
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_nrst,
  // Special-function-register bus
  input  wire spi_status_pkg::sfr_req_t i_sfr,
  output logic [7:0]                    o_sfr_rdata,
  // Interrupt
  input  wire logic                     i_irq_enable,
  output logic                          o_irq,
  // Master engine completion, same clock
  input  wire logic                     i_master_done,
  // Serial link
  input  wire logic                     i_sck,
  input  wire logic                     i_mosi,
  input  wire logic                     i_slave_select_n,
  output logic                          o_miso
);
  import spi_status_pkg::*;

  // ==========================================================
  // Link clock domain
  typedef struct packed {
    logic [7:0] shift;
    logic [7:0] rx_hold;
    logic       done_tgl;
    logic       edge_tgl;
    logic [7:0] tx_shift;
  } link_t;

  link_t      l_q;
  link_t      l_d;
  logic [2:0] bit_cnt_q;
  logic [2:0] bit_cnt_d;
  logic [7:0] tx_hold_q;

  always_comb begin
    l_d       = l_q;
    bit_cnt_d = bit_cnt_q + 3'h1;
    if (!i_slave_select_n) begin
      // Transition seen
      if (bit_cnt_q == BIT_ZERO) begin
        l_d.edge_tgl = ~l_q.edge_tgl;
        l_d.tx_shift = {tx_hold_q[6:0], 1'b0};
      end else begin
        l_d.tx_shift = {l_q.tx_shift[6:0], 1'b0};
      end
      l_d.shift = {l_q.shift[6:0], i_mosi};
      if (bit_cnt_q == LAST_BIT) begin
        l_d.rx_hold  = {l_q.shift[6:0], i_mosi};
        l_d.done_tgl = ~l_q.done_tgl;
      end
    end
  end

  // Link clock stops outside frames, so toggles clear with the system
  // reset; both sides of each toggle then start at the same level
  always_ff @(posedge i_sck or negedge i_nrst) begin
    if (!i_nrst) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // Deselect ends a cut frame at once, without waiting for a clock edge
  always_ff @(posedge i_sck or posedge i_slave_select_n or negedge i_nrst) begin
    if (!i_nrst) begin
      bit_cnt_q <= BIT_ZERO;
    end else if (i_slave_select_n) begin
      bit_cnt_q <= BIT_ZERO;
    end else begin
      bit_cnt_q <= bit_cnt_d;
    end
  end

  // First bit comes straight from the hold register before any edge
  assign o_miso = (bit_cnt_q == BIT_ZERO) ? tx_hold_q[7] : l_q.tx_shift[7];

  // ==========================================================
  // System clock domain
  typedef struct packed {
    logic [1:0] done_sync;
    logic       done_seen;
    logic [1:0] edge_sync;
    logic       edge_seen;
    logic [1:0] ss_sync;
    logic [7:0] control;
    logic [7:0] cfg_rw;
    logic       shifter_empty;
    logic       rx_buffer_empty;
    logic       tx_buffer_empty;
    logic [7:0] tx_buf;
    logic [7:0] tx_hold;
    logic [7:0] rx_buf;
    logic [7:0] rdata;
  } sys_t;

  sys_t s_q;
  sys_t s_d;
  logic done_ev;
  logic edge_ev;
  logic load_ev;
  logic select_pin_level;
  logic slave_selected_flag;
  logic busy;
  logic [7:0] control_view;
  logic [7:0] config_view;

  assign done_ev  = s_q.done_sync[1] ^ s_q.done_seen;
  assign edge_ev  = s_q.edge_sync[1] ^ s_q.edge_seen;
  // Load into an idle shifter or at frame end, never mid-frame
  assign load_ev  = !s_q.tx_buffer_empty && (s_q.shifter_empty || done_ev);
  // R10 pin level
  assign select_pin_level    = s_q.ss_sync[1];
  // R08 selected
  assign slave_selected_flag = ~s_q.ss_sync[1];
  assign busy = slave_selected_flag && !s_q.shifter_empty;

  always_comb begin
    control_view = s_q.control;
    control_view[CTL_TXEMPTY_BIT] = s_q.tx_buffer_empty;
    config_view  = s_q.cfg_rw;
    config_view[CFG_BUSY_BIT]     = busy;
    config_view[CFG_SELECTED_BIT] = slave_selected_flag;
    config_view[CFG_LEVEL_BIT]    = select_pin_level;
    config_view[CFG_SHEMPTY_BIT]  = s_q.shifter_empty;
    config_view[CFG_RXEMPTY_BIT]  = s_q.rx_buffer_empty;
  end

  always_comb begin
    s_d = s_q;
    s_d.done_sync = {s_q.done_sync[0], l_q.done_tgl};
    s_d.edge_sync = {s_q.edge_sync[0], l_q.edge_tgl};
    s_d.ss_sync   = {s_q.ss_sync[0], i_slave_select_n};
    s_d.done_seen = s_q.done_sync[1];
    s_d.edge_seen = s_q.edge_sync[1];

    // Register writes first so hardware sets below win, except the tx-empty set, which a same-cycle data write overrides
    if (i_sfr.wr && i_sfr.addr == ADDR_CONTROL) begin
      // R06 software clear
      s_d.control = i_sfr.wdata;
    end
    // R07 bit access
    if (i_sfr.bit_wr && i_sfr.addr == ADDR_CONTROL) begin
      s_d.control[i_sfr.bit_sel] = i_sfr.wdata[0];
    end
    s_d.control[CTL_TXEMPTY_BIT] = 1'b0;
    if (i_sfr.wr && i_sfr.addr == ADDR_CONFIG) begin
      s_d.cfg_rw = i_sfr.wdata;
    end
    if (i_sfr.wr && i_sfr.addr == ADDR_DATA) begin
      s_d.tx_buf = i_sfr.wdata;
      // R09 tx written
      s_d.tx_buffer_empty = 1'b0;
    end

    if (i_sfr.rd && i_sfr.addr == ADDR_DATA) begin
      s_d.rx_buffer_empty = 1'b1;
    end

    // R03 clock transition
    if (edge_ev) begin
      s_d.shifter_empty = 1'b0;
    end

    if (load_ev) begin
      s_d.tx_hold  = s_q.tx_buf;
      // R02 load clears
      s_d.shifter_empty = 1'b0;
      // R09 moved out
      if (!(i_sfr.wr && i_sfr.addr == ADDR_DATA)) begin
        s_d.tx_buffer_empty = 1'b1;
      end
    end

    if (done_ev) begin
      s_d.rx_buf          = l_q.rx_hold;
      s_d.rx_buffer_empty = 1'b0;
      // R01 all bits moved
      if (s_q.tx_buffer_empty) begin
        s_d.shifter_empty = 1'b1;
      end
    end

    // R04 set wins over clear
    if (done_ev || i_master_done) begin
      s_d.control[CTL_DONE_BIT] = 1'b1;
    end

    if (i_sfr.rd) begin
      case (i_sfr.addr)
        ADDR_CONTROL: s_d.rdata = control_view;
        ADDR_CONFIG:  s_d.rdata = config_view;
        ADDR_DATA:    s_d.rdata = s_q.rx_buf;
        default:      s_d.rdata = BYTE_RESET;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      s_q                 <= '0;
      s_q.ss_sync         <= 2'h3;
      s_q.control         <= CONTROL_RESET & ~8'h02;
      s_q.cfg_rw          <= BYTE_RESET;
      s_q.shifter_empty   <= CONFIG_RESET[CFG_SHEMPTY_BIT];
      s_q.rx_buffer_empty <= CONFIG_RESET[CFG_RXEMPTY_BIT];
      s_q.tx_buffer_empty <= CONTROL_RESET[CTL_TXEMPTY_BIT];
    end else begin
      s_q <= s_d;
    end
  end

  assign tx_hold_q   = s_q.tx_hold;
  assign o_sfr_rdata = s_q.rdata;
  // R05 interrupt request
  assign o_irq = s_q.control[CTL_DONE_BIT] & i_irq_enable;

endmodule : spi_status_flags

`default_nettype wire

/* File: testbench/spi_status_flags_assertions.sv */
// Checker for the serial status and flag block
`timescale 1ns/1ps
`default_nettype none
module spi_status_flags_assertions
  import spi_status_pkg::*;
(
  input wire logic                     i_ref_clk,
  input wire logic                     i_nrst,
  input wire spi_status_pkg::sfr_req_t i_sfr,
  input wire logic [7:0]               o_sfr_rdata,
  input wire logic                     i_irq_enable,
  input wire logic                     o_irq,
  input wire logic                     i_master_done,
  input wire logic                     i_slave_select_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  logic ctl, cfg, clr, unm;
  assign ctl = i_sfr.addr == ADDR_CONTROL;
  assign cfg = i_sfr.rd && i_sfr.addr == ADDR_CONFIG;
  assign unm = !ctl && !cfg && i_sfr.addr != ADDR_DATA;
  // Byte or bit write of zero into the done flag
  assign clr = ctl && ((i_sfr.wr && !i_sfr.wdata[7])
    || (i_sfr.bit_wr && i_sfr.bit_sel == 3'h7 && !i_sfr.wdata[0]));
  property p_irq_gate;
    !i_irq_enable && !$past(i_irq_enable) |-> !o_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq gate");
  property p_done_set;
    i_master_done && i_irq_enable |-> ##[1:3] o_irq;
  endproperty
  a_done_set: assert property (p_done_set) else $error("no set");
  property p_done_hold;
    o_irq && !clr && !$past(clr) |=> o_irq || !i_irq_enable;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("lost");
  property p_ctl_bit7;
    i_sfr.rd && ctl && o_irq && !$past(clr) |-> ##1 o_sfr_rdata[7];
  endproperty
  a_ctl_bit7: assert property (p_ctl_bit7) else $error("bit7");
  property p_rd_stand;
    !i_sfr.rd && !$past(i_sfr.rd) |=> $stable(o_sfr_rdata);
  endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("rdata");
  property p_unmapped;
    i_sfr.rd && unm |-> ##1 o_sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  property p_sel_hi;
    cfg && i_slave_select_n && $past(i_slave_select_n)
      && $past(i_slave_select_n, 2) |-> ##1 o_sfr_rdata[3:2] == 2'b01;
  endproperty
  a_sel_hi: assert property (p_sel_hi) else $error("sel hi");
  property p_sel_lo;
    cfg && !i_slave_select_n && !$past(i_slave_select_n)
      && !$past(i_slave_select_n, 2) |-> ##1 o_sfr_rdata[3:2] == 2'b10;
  endproperty
  a_sel_lo: assert property (p_sel_lo) else $error("sel lo");
endmodule : spi_status_flags_assertions
bind spi_status_flags spi_status_flags_assertions u_chk (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_sfr(i_sfr),
  .o_sfr_rdata(o_sfr_rdata), .i_irq_enable(i_irq_enable), .o_irq(o_irq),
  .i_master_done(i_master_done), .i_slave_select_n(i_slave_select_n));
`default_nettype wire

/* File: testbench/spi_link_master.sv */
// Link master model: framed serial clock, MSB first
`timescale 1ns/1ps
`default_nettype none
module spi_link_master (
  output logic      o_sck,
  output logic      o_mosi,
  output logic      o_ss_n,
  input  wire logic i_miso
);
  initial begin
    o_sck = 1'b0;
    o_mosi = 1'b0;
    o_ss_n = 1'b1;
  end
  // Clock stands still between frames
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    o_ss_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      o_mosi = tx[i];
      #62.5 rx[i] = i_miso;
      o_sck = 1'b1;
      #62.5 o_sck = 1'b0;
    end
    #62.5 o_ss_n = 1'b1;
    // Released line must not keep its last value
    o_mosi = ~o_mosi;
  endtask : xfer
endmodule : spi_link_master
`default_nettype wire

/* File: testbench/spi_status_flags_tb.sv */
// Testbench for the serial status and flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module spi_status_flags_tb;
  import spi_status_pkg::*;
  logic       ref_clk = 1'b0;
  logic       nrst    = 1'b1;
  sfr_req_t   sfr     = '0;
  logic       irq_en  = 1'b0;
  logic       mdone   = 1'b0;
  logic [7:0] rdata, rx, v;
  logic       irq, sck, mosi, ss_n, miso;
  int         num_errors = 0;
  int         cmp_count  = 0;
  always #2.5 ref_clk = ~ref_clk;
  spi_status_flags u_spi_status_flags (
    .i_ref_clk(ref_clk), .i_nrst(nrst), .i_sfr(sfr),
    .o_sfr_rdata(rdata), .i_irq_enable(irq_en), .o_irq(irq),
    .i_master_done(mdone), .i_sck(sck), .i_mosi(mosi),
    .i_slave_select_n(ss_n), .o_miso(miso));
  spi_link_master u_spi_link_master (
    .o_sck(sck), .o_mosi(mosi), .o_ss_n(ss_n), .i_miso(miso));
  // ==========================================================
  // Tasks
  task automatic close_out();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  task automatic wr(input logic bw, input logic [7:0] a, d,
                    input logic [2:0] s);
    @(negedge ref_clk);
    sfr = '{wr: !bw, bit_wr: bw, rd: 1'b0, addr: a, bit_sel: s, wdata: d};
    @(negedge ref_clk);
    sfr = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    sfr = '{rd: 1'b1, addr: a, default: '0};
    @(negedge ref_clk);
    sfr = '0;
    @(negedge ref_clk);
    d = rdata;
  endtask : rd
  task automatic wait_irq();
    for (int n = 0; irq !== 1'b1; n++) begin
      if (n == 80) begin
        num_errors++;
        $display("[FAIL] %0t no interrupt request", $time);
        close_out();
      end
      @(negedge ref_clk);
    end
  endtask : wait_irq
  initial begin
    #400000;
    num_errors++;
    $display("[FAIL] %0t run limit reached", $time);
    close_out();
  end
  // ==========================================================
  // Sequence
  initial begin
    #1 nrst = 1'b0;
    repeat (16) @(negedge ref_clk);
    nrst = 1'b1;
    rd(ADDR_CONTROL, v);
    `CHK(v, CONTROL_RESET)
    rd(ADDR_CONFIG, v);
    `CHK(v, CONFIG_RESET)
    rd(8'h55, v);
    `CHK(v, 8'h00)
    $display("test reset done");
    irq_en = 1'b1;
    mdone = 1'b1;
    @(negedge ref_clk);
    mdone = 1'b0;
    wait_irq();
    repeat (20) @(negedge ref_clk);
    `CHK(irq, 1'b1)
    rd(ADDR_CONTROL, v);
    `CHK(v[7], 1'b1)
    irq_en = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK(irq, 1'b0)
    wr(1'b1, ADDR_CONTROL, 8'h00, 3'h7);
    wr(1'b1, ADDR_CONTROL, 8'h01, 3'h0);
    rd(ADDR_CONTROL, v);
    `CHK(v, 8'h07)
    $display("test master flag done");
    irq_en = 1'b1;
    wr(1'b0, ADDR_DATA, 8'hA5, 3'h0);
    rd(ADDR_CONTROL, v);
    `CHK(v[1], 1'b1)
    rd(ADDR_CONFIG, v);
    `CHK(v[3:0], 4'b0101)
    #1.3;
    u_spi_link_master.xfer(8'h3C, rx);
    wait_irq();
    // Select level reaches the register two clocks after the pin
    repeat (3) @(negedge ref_clk);
    `CHK(rx, 8'hA5)
    rd(ADDR_CONFIG, v);
    `CHK(v[3:0], 4'b0110)
    rd(ADDR_DATA, v);
    `CHK(v, 8'h3C)
    rd(ADDR_CONFIG, v);
    `CHK(v[0], 1'b1)
    wr(1'b1, ADDR_CONTROL, 8'h00, 3'h7);
    fork
      begin
        #1.3;
        u_spi_link_master.xfer(8'h81, rx);
      end
      begin
        repeat (100) @(negedge ref_clk);
        rd(ADDR_CONFIG, v);
        `CHK(v[3:1], 3'b100)
        wr(1'b0, ADDR_DATA, 8'h5A, 3'h0);
        rd(ADDR_CONTROL, v);
        `CHK(v[1], 1'b0)
      end
    join
    wait_irq();
    rd(ADDR_DATA, v);
    `CHK(v, 8'h81)
    wr(1'b0, ADDR_CONFIG, 8'h70, 3'h0);
    rd(ADDR_CONFIG, v);
    `CHK(v, 8'h75)
    $display("test slave frames done");
    close_out();
  end
endmodule : spi_status_flags_tb
`default_nettype wire
